/* core/vfp_hour_counter.sv */
`timescale 1ns/1ps
module vfp_hour_counter #(
    parameter logic [39:0] HOUR_CYCLES = 40'd360000000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic clear,
    output logic [15:0] hours_q
);
    logic [39:0] tick_q;
    logic [39:0] tick_d;
    logic [15:0] hours_d;

    always_comb begin
        tick_d = tick_q;
        hours_d = hours_q;
        if (clear) begin
            tick_d = '0;
            hours_d = '0;
        end else if (run) begin
            if (tick_q == HOUR_CYCLES - 40'd1) begin
                tick_d = '0;
                // Saturate rather than wrap so a long run never looks short
                if (hours_q != 16'hFFFF) begin
                    hours_d = hours_q + 16'h0001;
                end
            end else begin
                tick_d = tick_q + 40'd1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= '0;
            hours_q <= '0;
        end else begin
            tick_q <= tick_d;
            hours_q <= hours_d;
        end
    end
endmodule

/* core/vfp_map.svh */
`ifndef VFP_MAP_SVH
`define VFP_MAP_SVH

// ==========================================================
// Register byte offsets
`define VFP_ADDR_CTRL 8'h00
`define VFP_ADDR_MEAN 8'h04
`define VFP_ADDR_STD 8'h08
`define VFP_ADDR_STAT 8'h0C
`define VFP_ADDR_THR 8'h10
`define VFP_ADDR_HOURS 8'h14

// ==========================================================
// Field positions
`define VFP_CTRL_MODE_LSB 0
`define VFP_CTRL_MULT_LSB 8
`define VFP_STAT_WARN_BIT 0
`define VFP_STAT_STATE_LSB 4
`define VFP_HOURS_CUM_LSB 16

// ==========================================================
// Reset values and constants
`define VFP_MEAN_RESET 16'h0000
`define VFP_STD_RESET 16'h0000
`define VFP_MULT_RESET 4'h0
`define VFP_MULT_DEFAULT 4'h5
`define VFP_CONT_HOURS_MIN 16'h0003
`define VFP_CUM_HOURS_MIN 16'h005A

// ==========================================================
// Timing: clock rate in Hz, one hour in seconds, cycles per hour
`define VFP_CLK_HZ 64'h0000_0000_05F5_E100
`define VFP_HOUR_S 64'h0000_0000_0000_0E10
`define VFP_HOUR_CYCLES (`VFP_CLK_HZ * `VFP_HOUR_S)

`endif

/* core/vfp_pkg.sv */
package vfp_pkg;

    // Encoding of the warning mode field
    typedef enum logic [1:0] {
        VFP_MODE_OFF,
        VFP_MODE_AUTO,
        VFP_MODE_MANUAL,
        VFP_MODE_RESET
    } vfp_mode_t;

    // Prediction state shown in the status register
    typedef enum logic [1:0] {
        VFP_ST_DISABLED,
        VFP_ST_PREPARING,
        VFP_ST_EXECUTING,
        VFP_ST_WARNING
    } vfp_status_t;

    typedef enum logic [1:0] {
        VFP_BOOT_SYNC,
        VFP_BOOT_LOAD,
        VFP_BOOT_RUN
    } vfp_boot_t;

endpackage

/* core/vfp_stats.sv */
`timescale 1ns/1ps
module vfp_stats #(
    parameter int W = 16,
    parameter int SHIFT = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic sample,
    input wire logic [W-1:0] level,
    output logic [W-1:0] mean,
    output logic [W-1:0] std_dev
);
    localparam int AW = W + SHIFT + 1;

    // Running averages scaled by 2^SHIFT; no divider or square root needed
    logic [AW-1:0] acc_mean_q;
    logic [AW-1:0] acc_mean_d;
    logic [AW-1:0] acc_dev_q;
    logic [AW-1:0] acc_dev_d;
    logic [W-1:0] dev_abs;
    logic [W-1:0] mad;

    assign mean = acc_mean_q[SHIFT +: W];
    assign mad = acc_dev_q[SHIFT +: W];
    // Mean absolute deviation times 1.25 approximates sigma for a normal spread
    assign std_dev = mad + (mad >> 2);

    always_comb begin
        acc_mean_d = acc_mean_q;
        acc_dev_d = acc_dev_q;
        dev_abs = (level > mean) ? (level - mean) : (mean - level);
        if (clear) begin
            acc_mean_d = '0;
            acc_dev_d = '0;
        end else if (sample) begin
            acc_mean_d = acc_mean_q + AW'(level) - (acc_mean_q >> SHIFT);
            acc_dev_d = acc_dev_q + AW'(dev_abs) - (acc_dev_q >> SHIFT);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_mean_q <= '0;
            acc_dev_q <= '0;
        end else begin
            acc_mean_q <= acc_mean_d;
            acc_dev_q <= acc_dev_d;
        end
    end
endmodule

/* core/vfp_top.sv */
`timescale 1ns/1ps
`include "vfp_map.svh"
module vfp_top
    import vfp_pkg::*;
#(
    parameter int W = 16,
    parameter int MULT_W = 4,
    parameter int EMA_SHIFT = 8,
    parameter logic [39:0] HOUR_CYCLES = 40'(`VFP_HOUR_CYCLES)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic vib_valid,
    input wire logic [W-1:0] vib_level,
    input wire logic motor_running,
    input wire logic pos_vel_mode,
    input wire logic [1:0] nv_mode,
    input wire logic [W-1:0] nv_mean,
    input wire logic [W-1:0] nv_std,
    input wire logic [MULT_W-1:0] nv_mult,
    output logic vibration_failure_warning,
    output logic [1:0] warning_mode_select
);
    localparam int TW = W + MULT_W + 1;
    localparam int NVW = 2 + 2 * W + MULT_W;

    // ==========================================================
    // Stored parameters arrive from the nonvolatile store on pins
    logic [NVW-1:0] nv_meta_q;
    logic [NVW-1:0] nv_sync_q;
    vfp_boot_t boot_q;
    vfp_boot_t boot_d;

    // No reset here: the stages keep sampling through reset, so a load right after
    // release sees the stored values and not the cleared stages
    always_ff @(posedge hclk) begin
        nv_meta_q <= {nv_mode, nv_mean, nv_std, nv_mult};
        nv_sync_q <= nv_meta_q;
    end

    // Load happens once, two edges after release; pins must stand through reset
    always_comb begin
        case (boot_q)
            VFP_BOOT_SYNC: boot_d = VFP_BOOT_LOAD;
            VFP_BOOT_LOAD: boot_d = VFP_BOOT_RUN;
            VFP_BOOT_RUN: boot_d = VFP_BOOT_RUN;
            default: boot_d = VFP_BOOT_SYNC;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q <= VFP_BOOT_SYNC;
        end else begin
            boot_q <= boot_d;
        end
    end

    // ==========================================================
    // AHB-Lite slave: writes zero wait, reads one wait state
    logic wr_pend_q;
    logic wr_pend_d;
    logic rd_pend_q;
    logic rd_pend_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic hreadyout_q;
    logic hreadyout_d;
    logic accept;
    logic [31:0] rd_word;

    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic [MULT_W-1:0] mult_q;
    logic [MULT_W-1:0] mult_d;
    logic [W-1:0] mean_q;
    logic [W-1:0] mean_d;
    logic [W-1:0] std_q;
    logic [W-1:0] std_d;
    logic [TW-1:0] thr_q;
    logic [TW-1:0] thr_d;
    logic warn_q;
    logic warn_d;
    logic [15:0] cont_hours;
    logic [15:0] cum_hours;
    logic [W-1:0] learn_mean;
    logic [W-1:0] learn_std;
    logic running;
    logic auto_on;
    logic learn_done;
    logic active;
    vfp_status_t status;

    assign accept = hsel && htrans[1] && hready;
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (addr_q)
            `VFP_ADDR_CTRL: begin
                rd_word[`VFP_CTRL_MODE_LSB +: 2] = mode_q;
                rd_word[`VFP_CTRL_MULT_LSB +: MULT_W] = mult_q;
            end
            `VFP_ADDR_MEAN: rd_word[W-1:0] = mean_q;
            `VFP_ADDR_STD: rd_word[W-1:0] = std_q;
            `VFP_ADDR_STAT: begin
                rd_word[`VFP_STAT_WARN_BIT] = warn_q;
                rd_word[`VFP_STAT_STATE_LSB +: 2] = status;
            end
            `VFP_ADDR_THR: rd_word[TW-1:0] = thr_q;
            `VFP_ADDR_HOURS: begin
                rd_word[15:0] = cont_hours;
                rd_word[`VFP_HOURS_CUM_LSB +: 16] = cum_hours;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        wr_pend_d = 1'b0;
        rd_pend_d = 1'b0;
        addr_d = addr_q;
        hrdata_d = hrdata_q;
        hreadyout_d = 1'b1;
        if (rd_pend_q) begin
            // Previous write has landed; thr_q trails a mean, std or ctrl write by one cycle, and warn_q and the hour counts a ctrl write
            hrdata_d = rd_word;
        end else if (accept) begin
            addr_d = haddr[7:0];
            wr_pend_d = hwrite;
            rd_pend_d = !hwrite;
            hreadyout_d = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q <= addr_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= hreadyout_d;
        end
    end

    // ==========================================================
    // Learning: hour counters and running statistics
    assign running = boot_q == VFP_BOOT_RUN;
    assign auto_on = running && (mode_q == VFP_MODE_AUTO);

    vfp_hour_counter #(
        .HOUR_CYCLES(HOUR_CYCLES)
    ) u_cont_hours (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(auto_on && motor_running),
        .clear(!auto_on || !motor_running),
        .hours_q(cont_hours)
    );

    vfp_hour_counter #(
        .HOUR_CYCLES(HOUR_CYCLES)
    ) u_cum_hours (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(auto_on && motor_running && pos_vel_mode),
        .clear(!auto_on),
        .hours_q(cum_hours)
    );

    vfp_stats #(
        .W(W),
        .SHIFT(EMA_SHIFT)
    ) u_stats (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(!auto_on),
        .sample(auto_on && motor_running && vib_valid),
        .level(vib_level),
        .mean(learn_mean),
        .std_dev(learn_std)
    );

    assign learn_done = auto_on
        && (cont_hours >= `VFP_CONT_HOURS_MIN)
        && (cum_hours >= `VFP_CUM_HOURS_MIN);

    // ==========================================================
    // Parameter registers
    always_comb begin
        mode_d = mode_q;
        mult_d = mult_q;
        mean_d = mean_q;
        std_d = std_q;
        if (boot_q == VFP_BOOT_LOAD) begin
            {mode_d, mean_d, std_d, mult_d} = nv_sync_q;
            if (nv_sync_q[NVW-1 -: 2] == VFP_MODE_RESET) begin
                mode_d = VFP_MODE_AUTO;
                mean_d = `VFP_MEAN_RESET;
                std_d = `VFP_STD_RESET;
            end
        end else begin
            if (learn_done) begin
                mean_d = learn_mean;
                std_d = learn_std;
                mode_d = VFP_MODE_MANUAL;
            end
            // A software write in the same cycle wins: it is the newer intent
            if (wr_pend_q && running) begin
                case (addr_q)
                    `VFP_ADDR_CTRL: begin
                        mode_d = hwdata[`VFP_CTRL_MODE_LSB +: 2];
                        mult_d = hwdata[`VFP_CTRL_MULT_LSB +: MULT_W];
                    end
                    `VFP_ADDR_MEAN: mean_d = hwdata[W-1:0];
                    `VFP_ADDR_STD: std_d = hwdata[W-1:0];
                    default: mode_d = mode_d;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= VFP_MODE_OFF;
            mult_q <= `VFP_MULT_RESET;
            mean_q <= `VFP_MEAN_RESET;
            std_q <= `VFP_STD_RESET;
        end else begin
            mode_q <= mode_d;
            mult_q <= mult_d;
            mean_q <= mean_d;
            std_q <= std_d;
        end
    end

    assign warning_mode_select = mode_q;

    // ==========================================================
    // Threshold and warning
    // Only manual mode compares; auto keeps quiet until it turns into manual
    assign active = running && (mode_q == VFP_MODE_MANUAL);

    always_comb begin
        logic [MULT_W-1:0] eff_mult;
        eff_mult = (mult_q == '0) ? MULT_W'(`VFP_MULT_DEFAULT) : mult_q;
        thr_d = TW'(mean_q) + TW'(std_q) * TW'(eff_mult);
        warn_d = warn_q;
        if (!active) begin
            warn_d = 1'b0;
        end else if (motor_running && vib_valid) begin
            if (TW'(vib_level) > thr_q) begin
                warn_d = 1'b1;
            end else if (TW'(vib_level) < thr_q) begin
                warn_d = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_q <= '0;
            warn_q <= 1'b0;
        end else begin
            thr_q <= thr_d;
            warn_q <= warn_d;
        end
    end

    assign vibration_failure_warning = warn_q;

    always_comb begin
        if (warn_q) begin
            status = VFP_ST_WARNING;
        end else if (active) begin
            status = VFP_ST_EXECUTING;
        end else if (auto_on) begin
            status = VFP_ST_PREPARING;
        end else begin
            status = VFP_ST_DISABLED;
        end
    end
endmodule

/* tb/tb_vibration_fault_predictor.sv */
`timescale 1ns/1ps
`include "vfp_map.svh"
module tb_vibration_fault_predictor;
    import vfp_pkg::*;
    // Short hour keeps the 90 hour learning span near 900 cycles
    localparam logic [39:0] HC = 40'h0A;
    typedef struct {logic [15:0] mean, sdev; logic [3:0] mult; logic [15:0] lvl;
        logic [31:0] thr; logic warn;} vfp_row_t;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, vibration_failure_warning;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, warning_mode_select;
    logic [1:0] nv_mode = 2'h0;
    logic [2:0] hsize;
    logic vib_valid = 1'b0;
    logic motor_running = 1'b1;
    logic pos_vel_mode = 1'b0;
    logic [15:0] vib_level = 16'h0000;
    int n_fail = 0;
    int num_checks = 0;
    vfp_row_t rows [7] = '{
        '{16'h0064, 16'h000A, 4'h3, 16'h0083, 32'h82, 1'b1},
        '{16'h0064, 16'h000A, 4'h0, 16'h0095, 32'h96, 1'b0},
        '{16'h0200, 16'h0040, 4'hF, 16'h05C0, 32'h5C0, 1'b0},
        '{16'hFFFF, 16'hFFFF, 4'hF, 16'hFFFF, 32'hFFFF0, 1'b0},
        '{16'h0010, 16'h0001, 4'h0, 16'h0016, 32'h15, 1'b1},
        '{16'h0010, 16'h0001, 4'h0, 16'h0015, 32'h15, 1'b1},
        '{16'h0010, 16'h0001, 4'h1, 16'h0010, 32'h11, 1'b0}};

    assign hready = hreadyout;
    vfp_top #(.HOUR_CYCLES(HC)) i_vfp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .vib_valid(vib_valid), .vib_level(vib_level), .motor_running(motor_running),
        .pos_vel_mode(pos_vel_mode), .nv_mode(nv_mode), .nv_mean(16'h0123),
        .nv_std(16'h0004), .nv_mult(4'h2),
        .vibration_failure_warning(vibration_failure_warning),
        .warning_mode_select(warning_mode_select));
    vfp_host_model i_vfp_host_model (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ========
    // Helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_vfp_host_model.xfer(1'b1, a, d, rd);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        i_vfp_host_model.xfer(1'b0, a, 32'h0, rd);
        check(name, rd, exp);
    endtask

    task automatic samp(input logic [15:0] lvl);
        @(posedge hclk);
        vib_valid <= 1'b1;
        vib_level <= lvl;
        @(posedge hclk);
        vib_valid <= 1'b0;
        vib_level <= ~lvl;
        #1;
    endtask

    task automatic boot(input logic [1:0] m);
        hresetn <= 1'b0;
        nv_mode <= m;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole run needs about 1100 cycles
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        wrap_up();
    end

    // ========
    // Tests
    initial begin
        int n;
        logic quiet;
        logic [31:0] lm;
        quiet = 1'b1;
        boot(VFP_MODE_OFF);
        rdc("ctrl", `VFP_ADDR_CTRL, 32'h200);
        rdc("thr", `VFP_ADDR_THR, 32'h12B);
        rdc("stat", `VFP_ADDR_STAT, 32'h0);
        rdc("unmapped", 8'h20, 32'h0);
        samp(16'hFFFF);
        check("warn off", vibration_failure_warning, 1'b0);
        wr(`VFP_ADDR_CTRL, 32'h3);
        samp(16'hFFFF);
        check("warn mode3", vibration_failure_warning, 1'b0);
        rdc("ctrl3", `VFP_ADDR_CTRL, 32'h3);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(`VFP_ADDR_MEAN, {16'h0, rows[i].mean});
            wr(`VFP_ADDR_STD, {16'h0, rows[i].sdev});
            wr(`VFP_ADDR_CTRL, {20'h0, rows[i].mult, 8'h02});
            rdc("ctrl", `VFP_ADDR_CTRL, {20'h0, rows[i].mult, 8'h02});
            rdc("thr", `VFP_ADDR_THR, rows[i].thr);
            samp(rows[i].lvl);
            check("warn", vibration_failure_warning, rows[i].warn);
        end
        @(posedge hclk);
        motor_running <= 1'b0;
        samp(16'hFFFF);
        check("warn stopped", vibration_failure_warning, 1'b0);
        $display("test table done");
        @(posedge hclk);
        boot(VFP_MODE_RESET);
        rdc("ctrl auto", `VFP_ADDR_CTRL, 32'h201);
        rdc("thr clear", `VFP_ADDR_THR, 32'h0);
        rdc("stat prep", `VFP_ADDR_STAT, 32'h10);
        @(posedge hclk);
        motor_running <= 1'b1;
        pos_vel_mode <= 1'b1;
        vib_valid <= 1'b1;
        vib_level <= 16'h0100;
        n = 0;
        while (warning_mode_select !== VFP_MODE_MANUAL && n < 2000) begin
            @(posedge hclk);
            n++;
            if (vibration_failure_warning !== 1'b0) quiet = 1'b0;
        end
        vib_valid <= 1'b0;
        check("learn span", {31'h0, n >= 900 && n <= 960}, 32'h1);
        check("quiet", {31'h0, quiet}, 32'h1);
        rdc("ctrl man", `VFP_ADDR_CTRL, 32'h202);
        i_vfp_host_model.xfer(1'b0, `VFP_ADDR_MEAN, 32'h0, rd);
        check("mean learned", {31'h0, rd != 32'h0}, 32'h1);
        lm = rd;
        samp(16'hFFFF);
        check("warn learned", vibration_failure_warning, 1'b1);
        rdc("stat warn", `VFP_ADDR_STAT, 32'h31);
        // Host answers a learned warning by raising the multiplier to six
        wr(`VFP_ADDR_CTRL, 32'h602);
        i_vfp_host_model.xfer(1'b0, `VFP_ADDR_STD, 32'h0, rd);
        rdc("thr six", `VFP_ADDR_THR, lm + rd * 32'h6);
        samp(16'h0000);
        check("warn cleared", vibration_failure_warning, 1'b0);
        $display("test learning done");
        wrap_up();
    end
endmodule

/* tb/vfp_host_model.sv */
`timescale 1ns/1ps
module vfp_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // ========
    // Host master: tuning is also rewritten while prediction is enabled
    // A spurious learned warning would be met with a multiplier of six or more
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        // Only the bench watchdog may end a wait for ready
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= w ? d : ~d;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        q = hrdata;
        // Stale write data would hide a late sample, so it is scrambled
        hwdata <= ~d;
    endtask
endmodule

/* tb/vfp_top_assertions.sv */
`timescale 1ns/1ps
module vfp_top_assertions
    import vfp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic vib_valid,
    input wire logic motor_running,
    input wire logic vibration_failure_warning,
    input wire logic [1:0] warning_mode_select
);
    // ========
    // Bus timing
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd_go = hsel && htrans[1] && hready && !hwrite;
    wire smp = vib_valid && motor_running;
    a_read_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait cycle");
    a_ready_idle: assert property (!rd_go && hreadyout |=> hreadyout)
        else $error("ready dropped without a read");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
        else $error("read data moved outside a read");
    // ========
    // Warning flag
    a_warn_manual: assert property ($past(warning_mode_select) != VFP_MODE_MANUAL
        |-> !vibration_failure_warning) else $error("warning outside manual mode");
    a_rise_sample: assert property ($rose(vibration_failure_warning) |-> $past(smp))
        else $error("warning rose without a running sample");
    a_fall_sample: assert property ($fell(vibration_failure_warning) &&
        $past(warning_mode_select) == VFP_MODE_MANUAL |-> $past(smp))
        else $error("warning fell without a running sample");
    a_warn_level: assert property (!$past(smp) &&
        $past(warning_mode_select) == VFP_MODE_MANUAL |-> $stable(vibration_failure_warning))
        else $error("warning moved with no sample");
    c_warn_up: cover property ($rose(vibration_failure_warning));
    c_learned: cover property ($past(warning_mode_select) == VFP_MODE_AUTO &&
        warning_mode_select == VFP_MODE_MANUAL);
    c_read: cover property (rd_go ##2 hreadyout);
endmodule

bind vfp_top vfp_top_assertions i_vfp_top_assertions (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .vib_valid(vib_valid),
    .motor_running(motor_running), .vibration_failure_warning(vibration_failure_warning),
    .warning_mode_select(warning_mode_select));
